// [ssx_pkg.sv]
// Shared opcodes, flag layout and widths for the subtract, skip and set unit.
package ssx_pkg;

   // Operand width of the accumulator and of one data memory byte.
   localparam int unsigned DATA_W = 8;

   // Operation select codes driven by the sequencer on OP.
   localparam logic [2:0] OP_BORROW_SUB_MEM  = 3'h0; // Result to memory.
   localparam logic [2:0] OP_DEC_SKIP_ZERO   = 3'h1; // Result to memory.
   localparam logic [2:0] OP_DEC_TO_ACC_SKIP = 3'h2; // Result to accumulator.
   localparam logic [2:0] OP_INC_SKIP_ZERO   = 3'h3; // Result to memory.
   localparam logic [2:0] OP_SET_BYTE        = 3'h4; // Whole byte to ones.
   localparam logic [2:0] OP_SET_BIT         = 3'h5; // One selected bit.

   // Bit positions inside the six-bit status flag vector.
   localparam int unsigned FLG_W      = 6;
   localparam int unsigned FLG_RANGE  = 0; // arith_range_flag.
   localparam int unsigned FLG_ZERO   = 1; // Zero flag.
   localparam int unsigned FLG_HALF   = 2; // half_carry_flag.
   localparam int unsigned FLG_CARRY  = 3; // Carry, set when no borrow.
   localparam int unsigned FLG_SIGNED = 4; // signed_result_flag.
   localparam int unsigned FLG_CHAIN  = 5; // chained_zero_flag.

   // Reset values of the result and flag holding registers, and the all-ones byte for a byte set.
   localparam logic [7:0] DATA_RST  = 8'h00;
   localparam logic [5:0] FLAGS_RST = 6'h00;
   localparam logic [7:0] ALL_ONES  = 8'hff;

   // Cycles from take to done for plain and for skip operations.
   localparam int unsigned PLAIN_CYCLES = 1;
   localparam int unsigned SKIP_CYCLES  = 2;

   // Controller states.
   typedef enum logic [1:0] {
      ST_IDLE,
      ST_EXEC,
      ST_DUMMY
   } ssx_state_t;

   // True when the result of an operation is all zeros.
   function automatic logic is_zero(input logic [7:0] v);
      return (v == 8'h00);
   endfunction

   // True for the operations that may skip the following instruction.
   function automatic logic is_skip_op(input logic [2:0] op);
      return (op == OP_DEC_SKIP_ZERO) || (op == OP_DEC_TO_ACC_SKIP) ||
             (op == OP_INC_SKIP_ZERO);
   endfunction

endpackage

// [ssx_alu.sv]
// Combinational arithmetic for the subtract, skip and set operations.
`timescale 1ns/1ps

module ssx_alu
   import ssx_pkg::*;
(
   input  wire logic [2:0]       op,        // Operation select.
   input  wire logic [7:0]       acc_val,   // Accumulator operand.
   input  wire logic [7:0]       mem_val,   // Data memory operand.
   input  wire logic [2:0]       bit_sel,   // Bit index for bit set.
   input  wire logic [FLG_W-1:0] flags_in,  // Current status flags.
   output logic      [7:0]       result,    // Operation result byte.
   output logic      [FLG_W-1:0] flags_out, // Flags after the operation.
   output logic                  skip_hit   // Skip operation reached zero.
);

   logic [8:0] diff;  // Nine-bit difference; bit 8 is the borrow out.
   logic [4:0] ndiff; // Low nibble difference; bit 4 is the half borrow.
   logic       bin;   // Borrow in, the complement of carry.

   // Subtraction and the flag derivation run every cycle; only the
   // borrow-subtract selection lets the new flags out.
   always_comb begin
      bin       = ~flags_in[FLG_CARRY];
      diff      = {1'b0, acc_val} - {1'b0, mem_val} - {8'h00, bin};
      ndiff     = {1'b0, acc_val[3:0]} - {1'b0, mem_val[3:0]} - {4'h0, bin};
      result    = mem_val;
      flags_out = flags_in;
      skip_hit  = 1'b0;
      case (op)
         OP_BORROW_SUB_MEM: begin
            // Accumulator minus memory minus inverted carry.
            result                = diff[7:0];
            flags_out[FLG_CARRY]  = ~diff[8];
            flags_out[FLG_ZERO]   = is_zero(diff[7:0]);
            flags_out[FLG_HALF]   = ~ndiff[4];
            flags_out[FLG_RANGE]  = (acc_val[7] ^ mem_val[7]) &
                                    (diff[7] ^ acc_val[7]);
            // Sign of the true result, corrected for overflow.
            flags_out[FLG_SIGNED] = (acc_val[7] ^ mem_val[7]) &
                                    (diff[7] ^ acc_val[7]) ^ diff[7];
            // Chained zero keeps a multi-byte zero test going.
            flags_out[FLG_CHAIN]  = is_zero(diff[7:0]) &
                                    flags_in[FLG_CHAIN];
         end
         OP_DEC_SKIP_ZERO, OP_DEC_TO_ACC_SKIP: begin
            // Eight-bit wrap: zero minus one gives all ones.
            result   = mem_val - 8'h01;
            skip_hit = is_zero(result);
         end
         OP_INC_SKIP_ZERO: begin
            // All ones plus one wraps to zero and skips.
            result   = mem_val + 8'h01;
            skip_hit = is_zero(result);
         end
         OP_SET_BYTE: begin
            result = ALL_ONES;
         end
         OP_SET_BIT: begin
            // Other seven bits pass through untouched.
            result          = mem_val;
            result[bit_sel] = 1'b1;
         end
         default: begin
            result = mem_val;
         end
      endcase
   end

endmodule // ssx_alu

// [ssx_exec.sv]
// Execution controller for the subtract, skip and set operations.
`timescale 1ns/1ps

// Behaviours
module ssx_exec
   import ssx_pkg::*;
(
   input  wire logic             REF_CLK,   // Core clock, 25 MHz.
   input  wire logic             RSTN,      // Asynchronous reset, low.
   input  wire logic             START,     // Request, taken with READY.
   input  wire logic [2:0]       OP,        // Operation select.
   input  wire logic [7:0]       ACC_IN,    // Accumulator value.
   input  wire logic [7:0]       MEM_RDATA, // Addressed memory byte.
   input  wire logic [2:0]       BIT_SEL,   // Bit index for bit set.
   input  wire logic [FLG_W-1:0] FLAGS_IN,  // Current status flags.
   output logic                  READY,     // Unit can take a request.
   output logic                  DONE,      // Operation finished pulse.
   output logic      [7:0]       MEM_WDATA, // Byte for data memory.
   output logic                  MEM_WE,    // Memory write pulse.
   output logic      [7:0]       ACC_OUT,   // Byte for the accumulator.
   output logic                  ACC_WE,    // Accumulator write pulse.
   output logic      [FLG_W-1:0] FLAGS_OUT, // New status flags.
   output logic                  FLAGS_WE,  // Flag write pulse.
   output logic                  SKIP,      // Next instruction skipped.
   output logic                  DUMMY      // Dummy cycle in progress.
);

   // All state of the controller in one word.
   typedef struct packed {
      ssx_state_t       st;        // Controller state.
      logic             two_cyc;   // Current operation is a skip op.
      logic [7:0]       mem_wdata; // Held memory write data.
      logic             mem_we;    // Memory write strobe.
      logic [7:0]       acc;       // Held accumulator data.
      logic             acc_we;    // Accumulator write strobe.
      logic [FLG_W-1:0] flags;     // Held flag vector.
      logic             flags_we;  // Flag write strobe.
      logic             skip;      // Skip decision of last operation.
   } ssx_regs_t;

   ssx_regs_t        s_reg;     // Registered state.
   ssx_regs_t        s_next;    // Next state.
   logic [7:0]       alu_res;   // Result byte from the arithmetic unit.
   logic [FLG_W-1:0] alu_flags; // Flags from the arithmetic unit.
   logic             alu_skip;  // Skip condition from the arithmetic unit.
   logic             take;      // A request is accepted this cycle.

   // Arithmetic works straight on the presented operands.
   ssx_alu u_alu (
      .op        (OP),
      .acc_val   (ACC_IN),
      .mem_val   (MEM_RDATA),
      .bit_sel   (BIT_SEL),
      .flags_in  (FLAGS_IN),
      .result    (alu_res),
      .flags_out (alu_flags),
      .skip_hit  (alu_skip)
   );

   // A request is refused through both cycles of a skip op, so READY
   // never shows high for a request that would be dropped; plain
   // operations can still follow each other back to back.
   assign READY = (s_reg.st != ST_DUMMY) &&
                  !(s_reg.st == ST_EXEC && s_reg.two_cyc);
   assign take  = START & READY;

   // Next-state logic: results are captured at the take edge and the
   // write strobes last exactly the first cycle after it.
   always_comb begin
      s_next          = s_reg;
      s_next.mem_we   = 1'b0;
      s_next.acc_we   = 1'b0;
      s_next.flags_we = 1'b0;
      case (s_reg.st)
         ST_IDLE, ST_EXEC: begin
            if (take) begin
               s_next.st      = ST_EXEC;
               s_next.two_cyc = is_skip_op(OP);
               s_next.skip    = alu_skip;
               case (OP)
                  OP_BORROW_SUB_MEM: begin
                     // Accumulator is left alone here.
                     s_next.mem_wdata = alu_res;
                     s_next.mem_we    = 1'b1;
                     s_next.flags     = alu_flags;
                     s_next.flags_we  = 1'b1;
                  end
                  OP_DEC_TO_ACC_SKIP: begin
                     // Memory is left alone here.
                     s_next.acc    = alu_res;
                     s_next.acc_we = 1'b1;
                  end
                  OP_DEC_SKIP_ZERO, OP_INC_SKIP_ZERO,
                  OP_SET_BYTE, OP_SET_BIT: begin
                     // Memory only; flags are never strobed.
                     s_next.mem_wdata = alu_res;
                     s_next.mem_we    = 1'b1;
                  end
                  default: begin
                     // Unknown codes complete without any write.
                     s_next.skip = 1'b0;
                  end
               endcase
            end else if (s_reg.st == ST_EXEC && s_reg.two_cyc) begin
               // Second cycle of a skip op holds off the next request.
               s_next.st = ST_DUMMY;
            end else begin
               s_next.st = ST_IDLE;
            end
         end
         ST_DUMMY: begin
            s_next.st = ST_IDLE;
         end
         default: begin
            s_next.st = ST_IDLE;
         end
      endcase
      // READY is low in the first cycle of a skip op, so nothing is
      // taken there; the held results stand while the dummy follows.
      if (s_reg.st == ST_EXEC && s_reg.two_cyc) begin
         s_next.st       = ST_DUMMY;
         s_next.mem_we   = 1'b0;
         s_next.acc_we   = 1'b0;
         s_next.flags_we = 1'b0;
         s_next.two_cyc  = s_reg.two_cyc;
         s_next.skip     = s_reg.skip;
         s_next.mem_wdata = s_reg.mem_wdata;
         s_next.acc      = s_reg.acc;
         s_next.flags    = s_reg.flags;
      end
   end

   // State register; reset gives idle with no strobes.
   always_ff @(posedge REF_CLK or negedge RSTN) begin
      if (!RSTN) begin
         s_reg <= '{st: ST_IDLE, two_cyc: 1'b0, mem_wdata: DATA_RST,
                    mem_we: 1'b0, acc: DATA_RST, acc_we: 1'b0,
                    flags: FLAGS_RST, flags_we: 1'b0, skip: 1'b0};
      end else begin
         s_reg <= s_next;
      end
   end

   // Outputs come from the state register.
   assign MEM_WDATA = s_reg.mem_wdata;
   assign MEM_WE    = s_reg.mem_we;
   assign ACC_OUT   = s_reg.acc;
   assign ACC_WE    = s_reg.acc_we;
   assign FLAGS_OUT = s_reg.flags;
   assign FLAGS_WE  = s_reg.flags_we;
   assign SKIP      = s_reg.skip;
   assign DUMMY     = (s_reg.st == ST_DUMMY);
   // Done marks the last cycle of every operation.
   assign DONE = (s_reg.st == ST_EXEC && !s_reg.two_cyc) ||
                 (s_reg.st == ST_DUMMY);

   // Checks of the operation results against their operands and of the cycle counts.
   default clocking cb @(posedge REF_CLK); endclocking
   default disable iff (!RSTN);

   // A take of each operation kind.
   sequence s_take_op(logic [2:0] code);
      take && (OP == code);
   endsequence
   // Skip ops: write cycle with READY low, then a dummy cycle that
   // closes the op.
   sequence s_two_cycle;
      (!DONE && !READY && (MEM_WE || ACC_WE)) ##1 (DUMMY && DONE && !READY);
   endsequence

   a_sub_result: assert property (s_take_op(OP_BORROW_SUB_MEM) |=>
      MEM_WE && !ACC_WE && MEM_WDATA == 8'($past(ACC_IN) -
      $past(MEM_RDATA) - {7'h00, !$past(FLAGS_IN[FLG_CARRY])}))
      else $error("Borrow subtract wrote a wrong memory byte.");
   a_carry_sense: assert property (s_take_op(OP_BORROW_SUB_MEM) |=>
      FLAGS_OUT[FLG_CARRY] == ({1'b0, $past(ACC_IN)} >= ({1'b0,
      $past(MEM_RDATA)} + {8'h00, !$past(FLAGS_IN[FLG_CARRY])})))
      else $error("Carry does not reflect the borrow.");
   // A flag write lasts one cycle unless another subtract follows.
   a_sub_flags: assert property (s_take_op(OP_BORROW_SUB_MEM) |=>
      FLAGS_WE && FLAGS_OUT[FLG_ZERO] == (MEM_WDATA == 8'h00) ##1
      FLAGS_WE == $past(take && OP == OP_BORROW_SUB_MEM))
      else $error("Subtract flags not written once.");
   a_dec_mem: assert property (s_take_op(OP_DEC_SKIP_ZERO) |=>
      MEM_WE && !FLAGS_WE && MEM_WDATA == 8'($past(MEM_RDATA) - 8'h01) &&
      SKIP == ($past(MEM_RDATA) == 8'h01))
      else $error("Decrement skip result wrong.");
   a_skip_cycles: assert property (take && is_skip_op(OP) |=>
      s_two_cycle)
      else $error("Skip operation is not two cycles.");
   a_plain_cycles: assert property (take && !is_skip_op(OP) |=>
      DONE && !DUMMY)
      else $error("Plain operation is not one cycle.");
   a_dec_acc: assert property (s_take_op(OP_DEC_TO_ACC_SKIP) |=>
      ACC_WE && !MEM_WE && !FLAGS_WE &&
      ACC_OUT == 8'($past(MEM_RDATA) - 8'h01) && SKIP == (ACC_OUT == 8'h00))
      else $error("Decrement to accumulator wrong.");
   a_set_byte: assert property (s_take_op(OP_SET_BYTE) |=>
      MEM_WE && !FLAGS_WE && MEM_WDATA == ALL_ONES && $stable(FLAGS_OUT))
      else $error("Byte set wrong.");
   a_set_bit: assert property (s_take_op(OP_SET_BIT) |=>
      MEM_WE && !FLAGS_WE &&
      MEM_WDATA == ($past(MEM_RDATA) | (8'h01 << $past(BIT_SEL))))
      else $error("Bit set wrong.");
   a_inc_mem: assert property (s_take_op(OP_INC_SKIP_ZERO) |=>
      MEM_WE && !FLAGS_WE && MEM_WDATA == 8'($past(MEM_RDATA) + 8'h01))
      else $error("Increment skip result wrong.");
   a_wrap_skip: assert property (s_take_op(OP_INC_SKIP_ZERO) &&
      MEM_RDATA == ALL_ONES |=> SKIP && MEM_WDATA == 8'h00)
      else $error("Increment of all ones did not wrap and skip.");

endmodule // ssx_exec

// [ssx_mem_model.sv]
// Data memory partner model for the subtract, skip and set unit.
`timescale 1ns/1ps

module ssx_mem_model (
   input  wire logic       clk,       // Core clock.
   input  wire logic       rstn,      // Asynchronous reset, low.
   input  wire logic [1:0] addr,      // Address of the current operand.
   input  wire logic       pre_we,    // Preload strobe from the sequencer.
   input  wire logic [7:0] pre_data,  // Preload byte from the sequencer.
   input  wire logic       mem_we,    // Write strobe from the unit.
   input  wire logic [7:0] mem_wdata, // Write byte from the unit.
   output logic      [7:0] rdata      // Byte at the current address.
);
   logic [7:0] mem_reg [4]; // Four data memory bytes.
   logic [1:0] wa_reg;      // Address of the op taken one edge earlier.

   // The unit writes one cycle after the take, when the sequencer may
   // already show the next address, so the write address is delayed.
   // A preload wins over a write-back that lands on the same edge.
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         wa_reg <= 2'h0;
         foreach (mem_reg[i]) mem_reg[i] <= 8'h00;
      end else begin
         wa_reg <= addr;
         if (pre_we) begin
            mem_reg[addr] <= pre_data;
         end else if (mem_we) begin
            mem_reg[wa_reg] <= mem_wdata;
         end
      end
   end

   // A preload byte is shown at once, so the unit sees its operand at
   // the take edge; the stored copy only lands on that same edge.
   assign rdata = pre_we ? pre_data : mem_reg[addr];
endmodule // ssx_mem_model

// [tb.sv]
// Self-checking testbench for the subtract, skip and set unit.
`timescale 1ns/1ps

module tb
   import ssx_pkg::*;
;
   logic REF_CLK = 1'b0, RSTN = 1'b0, START = 1'b0;
   logic [2:0] OP = 3'h0, BIT_SEL = 3'h0;
   logic [7:0] ACC_IN = 8'h00, pre_data = 8'h00, MEM_RDATA, MEM_WDATA, ACC_OUT;
   logic [FLG_W-1:0] FLAGS_IN = 6'h00, FLAGS_OUT, ef, lastf;
   logic [1:0] addr = 2'h0;
   logic READY, DONE, MEM_WE, ACC_WE, FLAGS_WE, SKIP, DUMMY;
   logic [31:0] seed = 32'd52;
   int err_total = 0, cmp_count = 0;
   int a, m, c, d, h, sd, r;       // Integer model of the taken op.
   logic [2:0] eo, eb;
   bit pend = 0, dum = 0, sk;

   always #20 REF_CLK = ~REF_CLK;   // 25 MHz core clock.

   ssx_exec uut (.REF_CLK(REF_CLK), .RSTN(RSTN), .START(START), .OP(OP),
      .ACC_IN(ACC_IN), .MEM_RDATA(MEM_RDATA), .BIT_SEL(BIT_SEL),
      .FLAGS_IN(FLAGS_IN), .READY(READY), .DONE(DONE),
      .MEM_WDATA(MEM_WDATA), .MEM_WE(MEM_WE), .ACC_OUT(ACC_OUT),
      .ACC_WE(ACC_WE), .FLAGS_OUT(FLAGS_OUT), .FLAGS_WE(FLAGS_WE),
      .SKIP(SKIP), .DUMMY(DUMMY));

   // The preload follows START; the model bypasses it to the read port.
   ssx_mem_model u_mem (.clk(REF_CLK), .rstn(RSTN), .addr(addr),
      .pre_we(START), .pre_data(pre_data), .mem_we(MEM_WE),
      .mem_wdata(MEM_WDATA), .rdata(MEM_RDATA));

   // Xorshift source with a fixed start for repeatable runs.
   function automatic logic [31:0] xs();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction

   // One comparison; four-state inequality so unknowns never match.
   task automatic chk(input logic [7:0] g, input logic [7:0] e);
      cmp_count++;
      if (g !== e) begin
         err_total++;
         $display("mismatch at %0t: got %h expected %h", $time, g, e);
      end
   endtask

   // Presents one op from a clock edge; START stays high so the next
   // call follows back to back. Skip ops hold START high with a byte set
   // through both of their cycles, which the unit must refuse.
   task automatic go(input logic [2:0] o, input logic [2:0] b,
                     input logic [7:0] mv, input logic [7:0] av,
                     input logic [5:0] fv);
      START <= 1'b1;
      OP <= o;
      BIT_SEL <= b;
      pre_data <= mv;
      ACC_IN <= av;
      FLAGS_IN <= fv;
      addr <= 2'(xs() % 4);
      @(posedge REF_CLK);
      if (is_skip_op(o)) begin
         OP <= OP_SET_BYTE;
         repeat (2) @(posedge REF_CLK);
      end
   endtask

   // Model: captures the request before the take edge, checks after it.
   always @(negedge REF_CLK) begin
      if (!RSTN) begin
         pend = 0;
         dum = 0;
         lastf = FLAGS_RST;
      end else begin
         if (dum) begin
            chk(DUMMY, 1'b1);
            chk(DONE, 1'b1);
            chk(READY, 1'b0);
            chk(MEM_WE | ACC_WE | FLAGS_WE, 1'b0);
            dum = 0;
         end else if (pend) begin
            sk = is_skip_op(eo);
            chk(DONE, !sk);
            chk(READY, !sk);
            chk(MEM_WE, eo != OP_DEC_TO_ACC_SKIP);
            chk(ACC_WE, eo == OP_DEC_TO_ACC_SKIP);
            chk(FLAGS_WE, eo == OP_BORROW_SUB_MEM);
            if (sk) chk(SKIP, r == 0);
            case (eo)
               OP_BORROW_SUB_MEM: begin
                  chk(MEM_WDATA, r[7:0]);
                  chk(FLAGS_OUT[FLG_CARRY], d >= 0);
                  chk(FLAGS_OUT, ef);
                  lastf = ef;
               end
               OP_DEC_TO_ACC_SKIP: chk(ACC_OUT, r[7:0]);
               OP_DEC_SKIP_ZERO: chk(MEM_WDATA, r[7:0]);
               OP_INC_SKIP_ZERO: chk(MEM_WDATA, r[7:0]);
               OP_SET_BYTE: chk(MEM_WDATA, r[7:0]);
               default: chk(MEM_WDATA, r[7:0]);
            endcase
            if (eo != OP_BORROW_SUB_MEM) chk(FLAGS_OUT, lastf);
            dum = sk;
            pend = 0;
         end else begin
            chk(MEM_WE | ACC_WE | FLAGS_WE, 1'b0);
         end
         if (!dum && START === 1'b1 && READY === 1'b1) begin
            eo = OP;
            eb = BIT_SEL;
            a = ACC_IN;
            m = MEM_RDATA;
            c = FLAGS_IN[FLG_CARRY];
            d = a - m - (1 - c);
            h = (a % 16) - (m % 16) - (1 - c);
            sd = (a - 256 * (a / 128)) - (m - 256 * (m / 128)) - (1 - c);
            ef = '0;
            case (eo)
               OP_BORROW_SUB_MEM: r = d & 255;
               OP_DEC_SKIP_ZERO, OP_DEC_TO_ACC_SKIP: r = (m + 255) % 256;
               OP_INC_SKIP_ZERO: r = (m + 1) % 256;
               OP_SET_BYTE: r = 255;
               default: r = m | (1 << eb);
            endcase
            ef[FLG_RANGE] = (sd > 127) || (sd < -128);
            ef[FLG_ZERO] = (r == 0);
            ef[FLG_HALF] = (h >= 0);
            ef[FLG_CARRY] = (d >= 0);
            ef[FLG_SIGNED] = ef[FLG_RANGE] ^ r[7];
            ef[FLG_CHAIN] = (r == 0) && FLAGS_IN[FLG_CHAIN];
            pend = 1;
         end
      end
   end

   // Prints the counts and the verdict, then ends the run.
   task automatic print_verdict();
      $display("comparisons %0d mismatches %0d", cmp_count, err_total);
      if (err_total == 0 && cmp_count > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask

   // Watchdog: the tests need a few hundred cycles at most.
   initial begin
      repeat (5000) @(posedge REF_CLK);
      err_total++;
      print_verdict();
   end

   initial begin
      repeat (4) @(posedge REF_CLK);
      RSTN <= 1'b1;
      @(posedge REF_CLK);
      go(OP_BORROW_SUB_MEM, 3'h0, 8'h05, 8'h05, 6'h28);
      go(OP_BORROW_SUB_MEM, 3'h0, 8'h05, 8'h05, 6'h20);
      go(OP_BORROW_SUB_MEM, 3'h0, 8'h01, 8'h80, 6'h08);
      go(OP_SET_BYTE, 3'h0, 8'h5a, 8'h11, 6'h3f);
      go(OP_INC_SKIP_ZERO, 3'h0, 8'hff, 8'h00, 6'h00);
      go(OP_INC_SKIP_ZERO, 3'h0, 8'h7f, 8'h00, 6'h00);
      go(OP_DEC_SKIP_ZERO, 3'h0, 8'h01, 8'h00, 6'h00);
      go(OP_DEC_SKIP_ZERO, 3'h0, 8'h00, 8'h00, 6'h00);
      go(OP_DEC_TO_ACC_SKIP, 3'h0, 8'h01, 8'h33, 6'h00);
      go(OP_DEC_TO_ACC_SKIP, 3'h0, 8'h80, 8'h33, 6'h00);
      for (int i = 0; i < 8; i++)
         go(OP_SET_BIT, i[2:0], 8'(xs()), 8'h00, 6'h00);
      $display("test directed done");
      for (int i = 0; i < 80; i++)
         go(3'(xs() % 6), 3'(xs()), 8'(xs()), 8'(xs()), 6'(xs()));
      START <= 1'b0;
      repeat (3) @(posedge REF_CLK);
      $display("test random done");
      print_verdict();
   end
endmodule // tb
